//--- logic/ses_map.svh
`ifndef SES_MAP_SVH
`define SES_MAP_SVH
// ==========================================
// register indices, byte address is 4x index
`define SES_IDX_PWR2 16'h0002
`define SES_IDX_DRC1 16'h0440
`define SES_IDX_DRC2 16'h0540
`define SES_IDX_DRC3 16'h0640
`define SES_IDX_DBNC 16'h0748
`define SES_IDX_LATCH 16'h0749
`define SES_IDX_LEVEL 16'h074A
// ==========================================
// field positions
`define SES_BIT_TSEN 14
`define SES_BIT_TOPDIS 13
`define SES_BIT_ACT_EN 6
`define SES_BIT_ACT_MODE 7
`define SES_LSB_CREST 9
`define SES_LSB_RMS 11
`define SES_BIT_DB_WARN 0
`define SES_BIT_DB_SHUT 1
`define SES_LSB_DB_SRC 2
// ==========================================
// reset values
`define SES_RST_TSEN 1'b1
`define SES_RST_TOPDIS 1'b1
`define SES_RST_ACT_EN 1'b0
`define SES_RST_ACT_MODE 1'b1
`define SES_RST_DBNC 4'h0
// ==========================================
// timing, clock 125 MHz
`define SES_CLK_MHZ 125
`define SES_ACC_PULSE_US 31
`define SES_ACC_PULSE_CYC (`SES_ACC_PULSE_US * `SES_CLK_MHZ)
`define SES_DBNC_TIME_US 1000
`define SES_DBNC_CYC (`SES_DBNC_TIME_US * `SES_CLK_MHZ)
// ==========================================
// thresholds in half-dB units
`define SES_RMS_BASE_HDB 8'h3C
`define SES_RMS_STEP_HDB 8'h03
`define SES_CREST_BASE_HDB 8'h18
`define SES_CREST_STEP_HDB 8'h0C
`endif

//--- logic/ses_pkg.sv
`default_nettype none
package ses_pkg;
   // ==========================================
   // status vector, thermal warning in bit 0
   typedef struct packed {
      logic [2:0] drc_activity;
      logic [1:0] src_lock;
      logic [1:0] fll_lock;
      logic accessory;
      logic thermal_shut;
      logic thermal_warn;
   } ses_status_t;
   // ==========================================
   // activity detect settings of one controller
   typedef struct packed {
      logic [4:0] activity_rms_threshold;
      logic [1:0] activity_crest_threshold;
      logic activity_detect_mode_select;
      logic activity_detect_enable;
   } ses_drc_cfg_t;
   // ==========================================
   // level measurement from one controller
   typedef struct packed {
      logic [7:0] rms_atten;
      logic [7:0] crest;
   } ses_meas_t;
endpackage
`default_nettype wire

//--- logic/ses_top.sv
// Operation
// - sensor enabled and shutdown control set: over-temperature forces audio outputs off
// - warning and shutdown statuses each have selectable de-bounce before irq and pin
// - warning and shutdown statuses raise events on both edges
// - accessory change gives one 31 us high pulse
// - every accessory change raises an accessory event, except a toggle in the first cycle after reset
// - a set status bit stays latched
// - latched bits readable any time and offered to the irq output
// - one lock flag per frequency-locked loop
// - each loop lock flag raises events on both edges
// - one lock flag per sample rate converter
// - converter lock flags pass selectable de-bounce first
// - de-bounced converter lock flags raise events on both edges
// - every status is offered for direct pin output
// - activity detect works only with controller and detect enable set
// - mode bit picks crest-factor (0) or rms (1) comparison
// - crest threshold codes give 12, 18, 24, 30 dB
// - rms threshold -30 dB, 1.5 dB lower per step, to -76.5 dB
// - three controllers, each with its own settings
// - activity detect raises events on rising edge only
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "ses_map.svh"
module ses_top #(
   parameter int DEBOUNCE_CYCLES = `SES_DBNC_CYC,
   parameter int ACC_PULSE_CYCLES = `SES_ACC_PULSE_CYC
) (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic THERMAL_WARN_RAW,
   input wire logic THERMAL_SHUT_RAW,
   input wire logic ACCESSORY_CHANGE_TOGGLE,
   input wire logic [1:0] FLL_LOCK_RAW,
   input wire logic [1:0] SRC_LOCK_RAW,
   input wire logic [2:0] DRC_RUNNING,
   input wire ses_pkg::ses_meas_t [2:0] DRC_MEAS,
   output logic AUDIO_OUTPUT_OFF,
   output ses_pkg::ses_status_t STATUS_LEVELS,
   output ses_pkg::ses_status_t LATCHED_EVENTS
);
   import ses_pkg::*;

   localparam int DW = $clog2(DEBOUNCE_CYCLES + 1);
   localparam int PW = $clog2(ACC_PULSE_CYCLES + 1);

   // ==========================================
   // elaboration checks
   if (DEBOUNCE_CYCLES < 1) begin : g_bad_dbnc
      $error("debounce count must be at least one");
   end
   if (ACC_PULSE_CYCLES < 1) begin : g_bad_pulse
      $error("pulse count must be at least one");
   end

   // ==========================================
   // functions
   // rms threshold as attenuation in half dB
   function automatic logic [7:0] rms_limit(input logic [4:0] code);
      rms_limit = `SES_RMS_BASE_HDB + `SES_RMS_STEP_HDB * {3'h0, code};
   endfunction

   // crest threshold in half dB
   function automatic logic [7:0] crest_limit(input logic [1:0] code);
      crest_limit = `SES_CREST_BASE_HDB + `SES_CREST_STEP_HDB * {6'h00, code};
   endfunction

   function automatic logic is_index(input logic [15:0] a, input logic [15:0] idx);
      is_index = (a == idx);
   endfunction

   // ==========================================
   // input synchronisers
   // every outside status except DRC_RUNNING and DRC_MEAS crosses two flops before use
   // a source other than the accessory toggle already high at reset shows one false edge after release
   logic [6:0] sync_a;
   logic [6:0] sync_b;
   logic [6:0] next_sync_a;

   always_comb begin
      next_sync_a = {SRC_LOCK_RAW, FLL_LOCK_RAW, ACCESSORY_CHANGE_TOGGLE,
                     THERMAL_SHUT_RAW, THERMAL_WARN_RAW};
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         sync_a <= 7'h00;
         sync_b <= 7'h00;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= sync_a;
      end
   end

   // ==========================================
   // register state
   logic thermal_sensor_enable;
   logic thermal_output_disable;
   logic [3:0] dbnc_sel;
   ses_drc_cfg_t drc_cfg [3];
   ses_status_t latched;
   logic next_thermal_sensor_enable;
   logic next_thermal_output_disable;
   logic [3:0] next_dbnc_sel;
   ses_drc_cfg_t next_drc_cfg [3];
   ses_status_t next_latched;

   // ==========================================
   // de-bounce of warning, shutdown, converter locks
   // a bypassed channel tracks its input at once
   // any cycle that matches the output restarts the count, so short glitches vanish
   logic [3:0] db_in;
   logic [3:0] db_out;
   logic [3:0] next_db_out;
   logic [DW-1:0] db_cnt [4];
   logic [DW-1:0] next_db_cnt [4];

   always_comb begin
      db_in[0] = sync_b[0] & thermal_sensor_enable;
      db_in[1] = sync_b[1] & thermal_sensor_enable;
      db_in[3:2] = sync_b[6:5];
      for (int i = 0; i < 4; i++) begin
         next_db_out[i] = db_out[i];
         next_db_cnt[i] = '0;
         if (!dbnc_sel[i]) begin
            next_db_out[i] = db_in[i];
         end else if (db_in[i] != db_out[i]) begin
            if (db_cnt[i] == DW'(DEBOUNCE_CYCLES - 1)) begin
               next_db_out[i] = db_in[i];
            end else begin
               next_db_cnt[i] = db_cnt[i] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         db_out <= 4'h0;
         for (int i = 0; i < 4; i++) begin
            db_cnt[i] <= '0;
         end
      end else begin
         db_out <= next_db_out;
         for (int i = 0; i < 4; i++) begin
            db_cnt[i] <= next_db_cnt[i];
         end
      end
   end

   // ==========================================
   // accessory pulse
   // the change arrives as a toggle so no pulse is lost in the crossing
   logic acc_prev;
   logic [PW-1:0] acc_cnt;
   logic acc_event;
   logic next_acc_prev;
   logic [PW-1:0] next_acc_cnt;
   // the toggle has no idle level, so edges count only once the
   // synchroniser and acc_prev hold real samples; a toggle in the
   // first cycle after reset, before the first sample, is lost
   logic [2:0] acc_warm;
   logic [2:0] next_acc_warm;

   always_comb begin
      next_acc_warm = {acc_warm[1:0], 1'b1};
      next_acc_prev = sync_b[2];
      acc_event = (sync_b[2] ^ acc_prev) & acc_warm[2];
      next_acc_cnt = acc_cnt;
      if (acc_event) begin
         next_acc_cnt = PW'(ACC_PULSE_CYCLES);
      end else if (acc_cnt != '0) begin
         next_acc_cnt = acc_cnt - 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         acc_prev <= 1'b0;
         acc_warm <= 3'h0;
         acc_cnt <= '0;
      end else begin
         acc_prev <= next_acc_prev;
         acc_warm <= next_acc_warm;
         acc_cnt <= next_acc_cnt;
      end
   end

   // ==========================================
   // activity detection
   // limits in half dB keep every threshold step a whole number
   logic [2:0] activity;

   always_comb begin
      for (int i = 0; i < 3; i++) begin
         if (drc_cfg[i].activity_detect_mode_select) begin
            activity[i] = DRC_MEAS[i].rms_atten <= rms_limit(drc_cfg[i].activity_rms_threshold);
         end else begin
            activity[i] = DRC_MEAS[i].crest >= crest_limit(drc_cfg[i].activity_crest_threshold);
         end
         activity[i] = activity[i] & DRC_RUNNING[i] & drc_cfg[i].activity_detect_enable;
      end
   end

   // ==========================================
   // status levels and events
   // levels leave one cycle late, in step with their latched events, except accessory, whose level trails its event by one cycle
   ses_status_t level;
   ses_status_t prev;
   ses_status_t event_set;
   ses_status_t next_prev;

   always_comb begin
      level.thermal_warn = db_out[0];
      level.thermal_shut = db_out[1];
      level.accessory = acc_cnt != '0;
      level.fll_lock = sync_b[4:3];
      level.src_lock = db_out[3:2];
      level.drc_activity = activity;
      next_prev = level;
      event_set.thermal_warn = level.thermal_warn ^ prev.thermal_warn;
      event_set.thermal_shut = level.thermal_shut ^ prev.thermal_shut;
      event_set.accessory = acc_event;
      event_set.fll_lock = level.fll_lock ^ prev.fll_lock;
      event_set.src_lock = level.src_lock ^ prev.src_lock;
      event_set.drc_activity = level.drc_activity & ~prev.drc_activity;
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         prev <= '0;
      end else begin
         prev <= next_prev;
      end
   end

   // ==========================================
   // ahb-lite slave
   // zero wait states; read data taken from next values
   // so a read right after a write sees the new value
   // hsize is not checked: every register is one whole word
   // unmapped indices read zero and drop writes
   logic wr_pend;
   logic [15:0] wr_idx;
   logic [31:0] rdata;
   logic next_wr_pend;
   logic [15:0] next_wr_idx;
   logic [31:0] next_rdata;
   logic addr_ok;
   logic [15:0] a_idx;

   always_comb begin
      addr_ok = HSEL & HTRANS[1] & HREADY;
      a_idx = HADDR[17:2];
      next_wr_pend = addr_ok & HWRITE;
      next_wr_idx = a_idx;
      next_thermal_sensor_enable = thermal_sensor_enable;
      next_thermal_output_disable = thermal_output_disable;
      next_dbnc_sel = dbnc_sel;
      for (int i = 0; i < 3; i++) begin
         next_drc_cfg[i] = drc_cfg[i];
      end
      next_latched = latched;
      if (wr_pend) begin
         if (is_index(wr_idx, `SES_IDX_PWR2)) begin
            next_thermal_sensor_enable = HWDATA[`SES_BIT_TSEN];
            next_thermal_output_disable = HWDATA[`SES_BIT_TOPDIS];
         end
         if (is_index(wr_idx, `SES_IDX_DBNC)) begin
            next_dbnc_sel = HWDATA[3:0];
         end
         for (int i = 0; i < 3; i++) begin
            if (is_index(wr_idx, 16'(`SES_IDX_DRC1 + 16'h0100 * i))) begin
               next_drc_cfg[i] = {HWDATA[`SES_LSB_RMS +: 5], HWDATA[`SES_LSB_CREST +: 2],
                                  HWDATA[`SES_BIT_ACT_MODE], HWDATA[`SES_BIT_ACT_EN]};
            end
         end
         // write one to clear
         if (is_index(wr_idx, `SES_IDX_LATCH)) begin
            next_latched = latched & ~HWDATA[9:0];
         end
      end
      // a new event wins over a clear in the same cycle
      next_latched = next_latched | event_set;
      next_rdata = 32'h0000_0000;
      if (addr_ok & ~HWRITE) begin
         if (is_index(a_idx, `SES_IDX_PWR2)) begin
            next_rdata[`SES_BIT_TSEN] = next_thermal_sensor_enable;
            next_rdata[`SES_BIT_TOPDIS] = next_thermal_output_disable;
         end
         if (is_index(a_idx, `SES_IDX_DBNC)) begin
            next_rdata[3:0] = next_dbnc_sel;
         end
         for (int i = 0; i < 3; i++) begin
            if (is_index(a_idx, 16'(`SES_IDX_DRC1 + 16'h0100 * i))) begin
               next_rdata[`SES_LSB_RMS +: 5] = next_drc_cfg[i].activity_rms_threshold;
               next_rdata[`SES_LSB_CREST +: 2] = next_drc_cfg[i].activity_crest_threshold;
               next_rdata[`SES_BIT_ACT_MODE] = next_drc_cfg[i].activity_detect_mode_select;
               next_rdata[`SES_BIT_ACT_EN] = next_drc_cfg[i].activity_detect_enable;
            end
         end
         if (is_index(a_idx, `SES_IDX_LATCH)) begin
            next_rdata[9:0] = next_latched;
         end
         if (is_index(a_idx, `SES_IDX_LEVEL)) begin
            next_rdata[9:0] = level;
         end
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         wr_pend <= 1'b0;
         wr_idx <= 16'h0000;
         rdata <= 32'h0000_0000;
         thermal_sensor_enable <= `SES_RST_TSEN;
         thermal_output_disable <= `SES_RST_TOPDIS;
         dbnc_sel <= `SES_RST_DBNC;
         for (int i = 0; i < 3; i++) begin
            drc_cfg[i] <= {5'h00, 2'h0, `SES_RST_ACT_MODE, `SES_RST_ACT_EN};
         end
         latched <= '0;
      end else begin
         wr_pend <= next_wr_pend;
         wr_idx <= next_wr_idx;
         rdata <= next_rdata;
         thermal_sensor_enable <= next_thermal_sensor_enable;
         thermal_output_disable <= next_thermal_output_disable;
         dbnc_sel <= next_dbnc_sel;
         for (int i = 0; i < 3; i++) begin
            drc_cfg[i] <= next_drc_cfg[i];
         end
         latched <= next_latched;
      end
   end

   // ==========================================
   // outputs
   // shutdown acts on the synchronised level, not the
   // de-bounced one, so protection is never delayed
   logic audio_off;
   logic next_audio_off;

   always_comb begin
      next_audio_off = thermal_sensor_enable & thermal_output_disable & sync_b[1];
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         audio_off <= 1'b0;
      end else begin
         audio_off <= next_audio_off;
      end
   end

   assign HRDATA = rdata;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign AUDIO_OUTPUT_OFF = audio_off;
   assign STATUS_LEVELS = prev;
   assign LATCHED_EVENTS = latched;

endmodule // ses_top
`default_nettype wire

//--- testbench/ses_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module ses_monitor #(
   parameter int ACC_PULSE_CYCLES = 20
) (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic THERMAL_SHUT_RAW,
   input wire logic [2:0] DRC_RUNNING,
   input wire logic AUDIO_OUTPUT_OFF,
   input wire ses_pkg::ses_status_t STATUS_LEVELS,
   input wire ses_pkg::ses_status_t LATCHED_EVENTS
);
   import ses_pkg::*;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // ==========================================
   // pulse length counter, retrigger not covered
   wire logic take = HSEL && HTRANS[1] && HREADY;
   wire logic acc = STATUS_LEVELS.accessory;
   logic [15:0] acc_cnt, next_acc_cnt;
   always_comb next_acc_cnt = acc ? acc_cnt + 16'h1 : 16'h0;
   always_ff @(posedge CORE_CLK) acc_cnt <= RESET ? 16'h0 : next_acc_cnt;
   // ==========================================
   // assertions
   a_bus_okay: assert property (HRESP == 1'b0 && HREADYOUT == 1'b1)
      else $error("bus answer not okay");
   a_rdata_idle: assert property (!$past(take && !HWRITE) |-> HRDATA == 32'h0)
      else $error("read data without read");
   // two sync flops and the output flop put the cause three samples back
   a_audio_cause: assert property ($rose(AUDIO_OUTPUT_OFF) |-> $past(THERMAL_SHUT_RAW, 3))
      else $error("outputs off without over-temperature");
   a_pulse_len: assert property ($fell(acc) |-> acc_cnt == 16'(ACC_PULSE_CYCLES))
      else $error("accessory pulse length wrong");
   a_sticky_hold: assert property (|($past(LATCHED_EVENTS) & ~LATCHED_EVENTS) |-> $past(take && HWRITE, 2))
      else $error("latched bit lost without write");
   a_both_edges: assert property (((STATUS_LEVELS ^ $past(STATUS_LEVELS)) & ~LATCHED_EVENTS & 10'h07B) == 10'h0)
      else $error("edge without event");
   a_drc_rise: assert property ((STATUS_LEVELS.drc_activity & ~$past(STATUS_LEVELS.drc_activity)
      & ~LATCHED_EVENTS.drc_activity) == 3'h0)
      else $error("activity rise without event");
   a_drc_fall: assert property (($past(STATUS_LEVELS.drc_activity) & ~STATUS_LEVELS.drc_activity
      & ~$past(LATCHED_EVENTS.drc_activity) & LATCHED_EVENTS.drc_activity) == 3'h0)
      else $error("activity fall raised event");
   a_act_gate: assert property ((STATUS_LEVELS.drc_activity & ~$past(DRC_RUNNING)
      & ~$past(DRC_RUNNING, 2)) == 3'h0)
      else $error("activity while controller stopped");
   c_pulse: cover property ($fell(acc));
   c_off: cover property ($rose(AUDIO_OUTPUT_OFF));
   c_clear: cover property (|($past(LATCHED_EVENTS) & ~LATCHED_EVENTS));
endmodule // ses_monitor
bind ses_top ses_monitor #(.ACC_PULSE_CYCLES(ACC_PULSE_CYCLES)) u_mon (.CORE_CLK, .RESET, .HSEL, .HTRANS,
   .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .THERMAL_SHUT_RAW, .DRC_RUNNING, .AUDIO_OUTPUT_OFF,
   .STATUS_LEVELS, .LATCHED_EVENTS);
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "ses_map.svh"
module tb;
   import ses_pkg::*;
   // ==========================================
   // shortened counts keep the run brief
   localparam int DB = 8;
   localparam int AP = 20;
   localparam logic [31:0] PWR = `SES_IDX_PWR2 * 32'h4;
   localparam logic [31:0] DBN = `SES_IDX_DBNC * 32'h4;
   localparam logic [31:0] LAT = `SES_IDX_LATCH * 32'h4;
   localparam logic [31:0] LVL = `SES_IDX_LEVEL * 32'h4;
   localparam logic [31:0] DRC [3] = '{`SES_IDX_DRC1 * 32'h4, `SES_IDX_DRC2 * 32'h4, `SES_IDX_DRC3 * 32'h4};
   localparam logic [15:0] TC [9] = '{16'hF8C0, 16'hF8C0, 16'h0640, 16'h0640, 16'h0040, 16'h00C0, 16'h00C0,
      16'h0080, 16'h00C0};
   localparam logic [7:0] TR [9] = '{8'h99, 8'h9A, 8'h00, 8'h00, 8'h00, 8'h3C, 8'h3D, 8'h00, 8'h00};
   localparam logic [7:0] TP [9] = '{8'h00, 8'h00, 8'h3C, 8'h3B, 8'h18, 8'h00, 8'h00, 8'hFF, 8'h00};
   localparam logic [8:0] TE = 9'h035;
   logic CORE_CLK = 1'b0;
   logic RESET = 1'b1;
   logic HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [31:0] HWDATA = 32'h0;
   logic THERMAL_WARN_RAW = 1'b0;
   logic THERMAL_SHUT_RAW = 1'b0;
   logic ACCESSORY_CHANGE_TOGGLE = 1'b0;
   logic [1:0] FLL_LOCK_RAW = 2'h0;
   logic [1:0] SRC_LOCK_RAW = 2'h0;
   logic [2:0] DRC_RUNNING = 3'h7;
   ses_meas_t [2:0] DRC_MEAS = '0;
   logic [31:0] HRDATA;
   logic HREADYOUT;
   logic HRESP;
   logic AUDIO_OUTPUT_OFF;
   ses_status_t STATUS_LEVELS;
   ses_status_t LATCHED_EVENTS;
   int err_total = 0;
   int comparisons = 0;
   ses_top #(.DEBOUNCE_CYCLES(DB), .ACC_PULSE_CYCLES(AP)) DUT (.CORE_CLK, .RESET, .HSEL, .HADDR, .HTRANS,
      .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .THERMAL_WARN_RAW,
      .THERMAL_SHUT_RAW, .ACCESSORY_CHANGE_TOGGLE, .FLL_LOCK_RAW, .SRC_LOCK_RAW, .DRC_RUNNING, .DRC_MEAS,
      .AUDIO_OUTPUT_OFF, .STATUS_LEVELS, .LATCHED_EVENTS);
   initial forever #4 CORE_CLK = ~CORE_CLK;
   // ==========================================
   // checking and bus tasks
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic lost(input string n);
      err_total++;
      $display("[FAIL] %s expected done seen timeout", n);
      finish_test();
   endtask
   // sampled at the falling edge: settled, and equal to what the next rising edge takes
   task automatic phase(output logic [31:0] q);
      logic r;
      r = 1'b0;
      for (int n = 0; n < 16 && !r; n++) begin
         @(negedge CORE_CLK);
         r = HREADYOUT === 1'b1;
         q = HRDATA;
         @(posedge CORE_CLK);
      end
      if (!r) lost("hready");
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= a;
      HWRITE <= w;
      phase(q);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      phase(q);
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] e, input string n);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(n, e, q);
   endtask
   task automatic wl(input int i, input logic v, input string n);
      logic s;
      s = ~v;
      for (int k = 0; k < 64 && s !== v; k++) begin
         @(negedge CORE_CLK);
         s = STATUS_LEVELS[i];
         @(posedge CORE_CLK);
      end
      if (s !== v) lost(n);
      chk(n, 32'(v), 32'(s));
   endtask
   task automatic aud(input logic e);
      @(negedge CORE_CLK);
      chk("outputs off", 32'(e), 32'(AUDIO_OUTPUT_OFF));
      @(posedge CORE_CLK);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CORE_CLK);
   endtask
   // ==========================================
   // main sequence
   initial begin
      int n;
      repeat (12) @(posedge CORE_CLK);
      RESET <= 1'b0;
      @(posedge CORE_CLK);
      rd(PWR, 32'h6000, "pwr2 reset");
      rd(DRC[0], 32'h0080, "drc1 reset");
      rd(DBN, 32'h0, "debounce reset");
      rd(LAT, 32'h0, "latched reset");
      wr(32'h7FF0, 32'hFFFF);
      rd(32'h7FF0, 32'h0, "unmapped");
      // record-path high-pass filter is the host's job, outside this block
      for (int k = 0; k < 3; k++) wr(DRC[k], 32'(k + 1) << 11 | 32'(k) << 9 | 32'h40);
      for (int k = 0; k < 3; k++) rd(DRC[k], 32'(k + 1) << 11 | 32'(k) << 9 | 32'h40, "drc cfg");
      for (int j = 0; j < 9; j++) begin
         wr(DRC[j % 3], 32'(TC[j]));
         DRC_MEAS[j % 3] <= {TR[j], TP[j]};
         DRC_RUNNING <= (j == 8) ? 3'h0 : 3'h7;
         // let the new setting reach the pin feed before looking
         cyc(2);
         wl(7 + j % 3, TE[j], "activity");
      end
      DRC_RUNNING <= 3'h7;
      wl(9, 1'b1, "rerun");
      wr(LAT, 32'h3FF);
      DRC_MEAS[2] <= 16'hFF00;
      wl(9, 1'b0, "drop");
      rd(LAT, 32'h0, "no fall event");
      DRC_MEAS[2] <= 16'h0000;
      wl(9, 1'b1, "rise");
      rd(LAT, 32'h200, "rise event");
      wr(LAT, 32'h3FF);
      THERMAL_SHUT_RAW <= 1'b1;
      wl(1, 1'b1, "shut level");
      aud(1'b1);
      rd(LVL, 32'h202, "live levels");
      rd(LAT, 32'h2, "shut event");
      wr(PWR, 32'h4000);
      rd(PWR, 32'h4000, "pwr2 rw");
      aud(1'b0);
      wr(PWR, 32'h0);
      wl(1, 1'b0, "sensor off");
      wr(PWR, 32'h6000);
      THERMAL_SHUT_RAW <= 1'b0;
      // the re-enable pulse must settle before the next clear
      cyc(8);
      wr(DBN, 32'h1);
      wr(LAT, 32'h3FF);
      THERMAL_WARN_RAW <= 1'b1;
      cyc(3);
      THERMAL_WARN_RAW <= 1'b0;
      cyc(DB + 6);
      rd(LAT, 32'h0, "warn glitch");
      THERMAL_WARN_RAW <= 1'b1;
      wl(0, 1'b1, "warn level");
      rd(LAT, 32'h1, "warn rise");
      wr(LAT, 32'h3FF);
      rd(LAT, 32'h0, "cleared");
      THERMAL_WARN_RAW <= 1'b0;
      wl(0, 1'b0, "warn low");
      rd(LAT, 32'h1, "warn fall");
      for (int t = 0; t < 2; t++) begin
         wr(LAT, 32'h3FF);
         ACCESSORY_CHANGE_TOGGLE <= ~ACCESSORY_CHANGE_TOGGLE;
         wl(2, 1'b1, "pulse start");
         for (n = 1; n < 99; n++) begin
            @(negedge CORE_CLK);
            if (STATUS_LEVELS[2] !== 1'b1) break;
         end
         @(posedge CORE_CLK);
         chk("pulse width", 32'(AP), 32'(n));
         rd(LAT, 32'h4, "accessory event");
      end
      wr(DBN, 32'hC);
      for (int b = 0; b < 4; b++) begin
         wr(LAT, 32'h3FF);
         if (b > 1) begin
            {SRC_LOCK_RAW, FLL_LOCK_RAW} <= 4'(1 << b);
            cyc(2);
            {SRC_LOCK_RAW, FLL_LOCK_RAW} <= 4'h0;
            cyc(DB + 6);
            rd(LAT, 32'h0, "lock glitch");
         end
         {SRC_LOCK_RAW, FLL_LOCK_RAW} <= 4'(1 << b);
         wl(3 + b, 1'b1, "lock rise");
         rd(LAT, 32'h8 << b, "lock rise event");
         wr(LAT, 32'h3FF);
         {SRC_LOCK_RAW, FLL_LOCK_RAW} <= 4'h0;
         wl(3 + b, 1'b0, "lock fall");
         rd(LAT, 32'h8 << b, "lock fall event");
      end
      // mid-run reset with the toggle left high: no false accessory edge
      wr(PWR, 32'h0);
      ACCESSORY_CHANGE_TOGGLE <= 1'b1;
      RESET <= 1'b1;
      cyc(12);
      RESET <= 1'b0;
      cyc(8);
      rd(LAT, 32'h0, "no edge after reset");
      rd(PWR, 32'h6000, "pwr2 after reset");
      rd(DRC[2], 32'h0080, "drc3 after reset");
      finish_test();
   end
endmodule // tb
`default_nettype wire
